/* File: tpc_params.svh */
// holds the offsets, field positions, reset values and counts of the block
// assumes inclusion by bare name from every design file that needs them
`ifndef TPC_PARAMS_SVH
`define TPC_PARAMS_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define TPC_OFS_SAMPLE 8'h00
`define TPC_OFS_STATUS 8'h04
`define TPC_OFS_RESULT 8'h08
`define TPC_OFS_INT_STAT 8'h0C
`define TPC_OFS_INT_MASK 8'h10

// ****************************************************************
// control byte fields, counted after the start bit
// ****************************************************************
`define TPC_CB_CHAN_HI 6
`define TPC_CB_CHAN_LO 4
`define TPC_CB_MODE8 3
`define TPC_CB_SINGLE 2
`define TPC_CB_PD1 1
`define TPC_CB_PD0 0
`define TPC_CB_LAST_CNT 3'h6

// ****************************************************************
// result shifting
// ****************************************************************
`define TPC_TOP_FULL 4'hB
`define TPC_TOP_EIGHT 4'h7

// ****************************************************************
// interrupt bits and reset values
// ****************************************************************
`define TPC_INT_BYTE 0
`define TPC_INT_DONE 1
`define TPC_INT_ABORT 2
`define TPC_RST_SAMPLE 12'h000
`define TPC_RST_MASK 3'h0
`define TPC_RST_ADC_ON 1'b1
`define TPC_RST_REF_ON 1'b0
`define TPC_RST_PEN_EN 1'b1
`define TPC_RST_SYNC 4'h1

`endif

/* File: tpc_pkg.sv */
// holds the types shared by the converter control files
// assumes the constants come from tpc_params.svh
package tpc_pkg;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CMD = 5'b00010,
    ST_ACQ = 5'b00100,
    ST_CONV = 5'b01000,
    ST_DATA = 5'b10000
  } tpc_state_type;

endpackage

/* File: tpc_sync.sv */
// holds a two-stage synchroniser for pins arriving from outside pclk
// assumes the inputs are slow levels relative to pclk
`timescale 1ns/1ps
`default_nettype none

module tpc_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // ****************************************************************
  // first stage feeds only the second
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // tpc_sync
`default_nettype wire

/* File: tpc_shifter.sv */
// holds the result shift register, most significant bit first
// assumes load and shift are single-cycle strobes on pclk
`timescale 1ns/1ps
`default_nettype none
`include "tpc_params.svh"

module tpc_shifter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic shift,
  input wire logic eight_bit,
  input wire logic [11:0] value,
  output logic next_bit,
  output logic on_bit1
);

  logic [11:0] sr_q;
  logic [3:0] idx_q;
  logic [11:0] load_w;

  // short mode keeps the top eight bits, so the code stays straight binary
  assign load_w = eight_bit ? {value[11:4], 4'h0} : value;
  assign next_bit = sr_q[10];
  assign on_bit1 = (idx_q == 4'h1);

  // ****************************************************************
  // shift register and bit index
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_q <= 12'h000;
      idx_q <= 4'h0;
    end else if (load) begin
      sr_q <= load_w;
      idx_q <= eight_bit ? `TPC_TOP_EIGHT : `TPC_TOP_FULL;
    end else if (shift) begin
      sr_q <= {sr_q[10:0], 1'b0};
      idx_q <= idx_q - 4'h1;
    end
  end

endmodule // tpc_shifter
`default_nettype wire

/* File: tpc_ctrl.sv */
// holds the converter control: link sampling, sequence, power, APB regs
// assumes pclk runs well above serial_clock; link pins are asynchronous
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tpc_params.svh"

// Behaviour
// - results are unsigned straight binary codes
// - short mode ends four clocks sooner
// - adc bit one full power, zero auto-off
// - single-ended drives panel only while acquiring
// - differential drives panel through conversion too
// - select high aborts conversion, powers down
// - select high leaves reference unchanged
// - powered after reset until adc bit zero
// - two power bits decode four modes
// - reference setting latched when busy rises
// - conversion ends on fall after bit1
// - adc bit one keeps pen interrupt off
module tpc_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic cs_n,
  input wire logic serial_clock,
  input wire logic din,
  input wire logic panel_touched,
  output logic dout,
  output logic dout_oe,
  output logic busy,
  output logic busy_oe,
  output logic pen_touch_irq_n,
  output logic panel_drive,
  output logic adc_powered,
  output logic ref_powered
);

  // ****************************************************************
  // decode functions
  // ****************************************************************
  // returns {reference on, adc held on}; 00 auto, 01 adc, 10 ref, 11 both
  function automatic logic [1:0] power_decode(input logic [1:0] pd);
    power_decode = {pd[1], pd[0]};
  endfunction

  // channels that measure the panel itself
  function automatic logic is_touch(input logic [2:0] ch);
    is_touch = (ch == 3'h1) || (ch == 3'h3) || (ch == 3'h4) ||
               (ch == 3'h5);
  endfunction

  // ****************************************************************
  // pin synchronisers and edge finding
  // ****************************************************************
  logic [3:0] pins_s;
  logic cs_s, clk_s, din_s, touch_s;
  logic clk_prev_q, cs_prev_q;
  logic rise_w, fall_w, cs_rise_w, cs_low_w;

  tpc_sync #(.W(4), .RST_VAL(`TPC_RST_SYNC)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in({panel_touched, din, serial_clock, cs_n}),
    .sync_out(pins_s)
  );

  assign cs_s = pins_s[0];
  assign clk_s = pins_s[1];
  assign din_s = pins_s[2];
  assign touch_s = pins_s[3];
  assign rise_w = clk_s & ~clk_prev_q;
  assign fall_w = ~clk_s & clk_prev_q;
  assign cs_rise_w = cs_s & ~cs_prev_q;
  assign cs_low_w = ~cs_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      clk_prev_q <= clk_s;
      cs_prev_q <= cs_s;
    end
  end

  // ****************************************************************
  // control byte capture
  // ****************************************************************
  tpc_pkg::tpc_state_type state_q, state_d;
  logic [5:0] cmd_sr_q;
  logic [2:0] bit_cnt_q;
  logic [6:0] byte_w;
  logic [2:0] chan_q, chan_d;
  logic mode8_q, single_q, single_d;
  logic [1:0] pd_q;
  logic byte_done_w, busy_rise_w, busy_fall_w, shift_w, conv_end_w;
  logic abort_w, next_bit_w, on_bit1_w;

  assign byte_w = {cmd_sr_q, din_s};
  assign byte_done_w = (state_q == tpc_pkg::ST_CMD) & rise_w & cs_low_w &
                       (bit_cnt_q == `TPC_CB_LAST_CNT);
  assign busy_rise_w = (state_q == tpc_pkg::ST_ACQ) & fall_w & cs_low_w;
  assign busy_fall_w = (state_q == tpc_pkg::ST_CONV) & fall_w & cs_low_w;
  assign shift_w = (state_q == tpc_pkg::ST_DATA) & fall_w & cs_low_w;
  assign conv_end_w = shift_w & on_bit1_w;
  // select rising mid-measurement drops the conversion
  assign abort_w = cs_rise_w & (state_q != tpc_pkg::ST_IDLE) &
                   (state_q != tpc_pkg::ST_CMD);
  assign chan_d = byte_done_w ?
                  byte_w[`TPC_CB_CHAN_HI:`TPC_CB_CHAN_LO] : chan_q;
  assign single_d = byte_done_w ? byte_w[`TPC_CB_SINGLE] : single_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_sr_q <= 6'h00;
      bit_cnt_q <= 3'h0;
    end else if (state_q == tpc_pkg::ST_IDLE) begin
      bit_cnt_q <= 3'h0;
    end else if ((state_q == tpc_pkg::ST_CMD) && rise_w) begin
      cmd_sr_q <= byte_w[5:0];
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_q <= 3'h0;
      mode8_q <= 1'b0;
      single_q <= 1'b0;
      pd_q <= 2'h0;
    end else if (byte_done_w) begin
      chan_q <= chan_d;
      mode8_q <= byte_w[`TPC_CB_MODE8];
      single_q <= single_d;
      pd_q <= byte_w[`TPC_CB_PD1:`TPC_CB_PD0];
    end
  end

  // ****************************************************************
  // measurement sequence
  // ****************************************************************
  // a start bit arriving during result shifting is ignored, so bytes
  // cannot overlap the previous result
  always_comb begin
    state_d = state_q;
    case (state_q)
      tpc_pkg::ST_IDLE: begin
        if (cs_low_w && rise_w && din_s) state_d = tpc_pkg::ST_CMD;
      end
      tpc_pkg::ST_CMD: begin
        if (byte_done_w) state_d = tpc_pkg::ST_ACQ;
      end
      tpc_pkg::ST_ACQ: begin
        if (busy_rise_w) state_d = tpc_pkg::ST_CONV;
      end
      tpc_pkg::ST_CONV: begin
        if (busy_fall_w) state_d = tpc_pkg::ST_DATA;
      end
      tpc_pkg::ST_DATA: begin
        if (conv_end_w) state_d = tpc_pkg::ST_IDLE;
      end
      default: state_d = tpc_pkg::ST_IDLE;
    endcase
    if (cs_s) state_d = tpc_pkg::ST_IDLE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_q <= tpc_pkg::ST_IDLE;
    else state_q <= state_d;
  end

  // ****************************************************************
  // result path
  // ****************************************************************
  logic [11:0] sample_q, code_q, result_q;
  logic dout_d;

  tpc_shifter u_shift (
    .clk(pclk),
    .rst_n(presetn),
    .load(busy_fall_w),
    .shift(shift_w),
    .eight_bit(mode8_q),
    .value(code_q),
    .next_bit(next_bit_w),
    .on_bit1(on_bit1_w)
  );

  // code is the sample as an unsigned binary number, zero at the bottom
  assign dout_d = cs_s ? 1'b0 : busy_fall_w ? code_q[11] :
                  shift_w ? next_bit_w : fall_w ? 1'b0 : dout;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_q <= 12'h000;
      result_q <= 12'h000;
    end else begin
      if (busy_rise_w) code_q <= sample_q;
      if (conv_end_w) begin
        result_q <= mode8_q ? {4'h0, code_q[11:4]} : code_q;
      end
    end
  end

  // ****************************************************************
  // power, drivers and pin outputs
  // ****************************************************************
  logic adc_d, ref_d, pen_en_q, pen_en_d, drive_d, pen_n_d, meas_d;
  logic [1:0] pwr_w;

  assign pwr_w = power_decode(pd_q);
  assign adc_d = cs_rise_w ? 1'b0 :
                 byte_done_w ? 1'b1 :
                 conv_end_w ? pwr_w[0] : adc_powered;
  assign ref_d = busy_rise_w ? pwr_w[1] : ref_powered;
  assign pen_en_d = (byte_done_w & byte_w[`TPC_CB_PD0]) ? 1'b0 :
                    (conv_end_w & ~pd_q[0]) ? 1'b1 : pen_en_q;
  assign meas_d = (state_d == tpc_pkg::ST_CONV) |
                  (state_d == tpc_pkg::ST_DATA);
  assign drive_d = is_touch(chan_d) & ((state_d == tpc_pkg::ST_ACQ) |
                   (~single_d & meas_d));
  // low during panel measurements, high during others, else the touch
  assign pen_n_d = ((state_d == tpc_pkg::ST_ACQ) | meas_d) ?
                   ~is_touch(chan_d) :
                   ~(pen_en_d & touch_s);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_powered <= `TPC_RST_ADC_ON;
      ref_powered <= `TPC_RST_REF_ON;
      pen_en_q <= `TPC_RST_PEN_EN;
      panel_drive <= 1'b0;
      pen_touch_irq_n <= 1'b1;
      busy <= 1'b0;
      dout <= 1'b0;
      dout_oe <= 1'b0;
      busy_oe <= 1'b0;
    end else begin
      adc_powered <= adc_d;
      ref_powered <= ref_d;
      pen_en_q <= pen_en_d;
      panel_drive <= drive_d;
      pen_touch_irq_n <= pen_n_d;
      busy <= (state_d == tpc_pkg::ST_CONV);
      dout <= dout_d;
      dout_oe <= cs_low_w;
      busy_oe <= cs_low_w;
    end
  end

  // ****************************************************************
  // APB slave, one wait state per transfer
  // ****************************************************************
  logic [2:0] int_stat_q, int_stat_d, mask_q, events_w, w1c_w;
  logic access_w, wr_w, hit_w;
  logic sel_sample, sel_status, sel_result, sel_stat, sel_mask;
  logic [31:0] rd_mux_w;

  assign access_w = psel & penable;
  assign wr_w = access_w & pready & pwrite;
  assign sel_sample = (paddr == `TPC_OFS_SAMPLE);
  assign sel_status = (paddr == `TPC_OFS_STATUS);
  assign sel_result = (paddr == `TPC_OFS_RESULT);
  assign sel_stat = (paddr == `TPC_OFS_INT_STAT);
  assign sel_mask = (paddr == `TPC_OFS_INT_MASK);
  assign hit_w = sel_sample | sel_status | sel_result | sel_stat | sel_mask;
  assign rd_mux_w = sel_sample ? {20'h00000, sample_q} :
                    sel_status ? {23'h000000, state_q, pen_en_q,
                                  ref_powered, adc_powered, busy} :
                    sel_result ? {20'h00000, result_q} :
                    sel_stat ? {29'h00000000, int_stat_q} :
                    sel_mask ? {29'h00000000, mask_q} : 32'h00000000;
  assign events_w = {abort_w, conv_end_w, byte_done_w};
  assign w1c_w = (wr_w & sel_stat) ? pwdata[2:0] : 3'h0;
  // an event in the clearing cycle survives the clear
  assign int_stat_d = (int_stat_q & ~w1c_w) | events_w;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= access_w & ~pready;
      pslverr <= access_w & ~pready & ~hit_w;
      if (access_w && !pready) prdata <= pwrite ? 32'h00000000 : rd_mux_w;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_q <= `TPC_RST_SAMPLE;
      mask_q <= `TPC_RST_MASK;
      int_stat_q <= 3'h0;
      irq <= 1'b0;
    end else begin
      if (wr_w && sel_sample) sample_q <= pwdata[11:0];
      if (wr_w && sel_mask) mask_q <= pwdata[2:0];
      int_stat_q <= int_stat_d;
      irq <= |(int_stat_d & mask_q);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [3:0] falls_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) falls_q <= 4'h0;
    else if (busy_fall_w) falls_q <= 4'h0;
    else if (shift_w) falls_q <= falls_q + 4'h1;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_abort_idle: assert property (abort_w |=> !busy &&
    state_q == tpc_pkg::ST_IDLE) else $error("select rise kept busy");
  a_abort_power: assert property (cs_rise_w |=> !adc_powered)
    else $error("adc stayed on after select rise");
  a_ref_keep: assert property (cs_rise_w |=> $stable(ref_powered))
    else $error("reference changed on select rise");
  a_ref_latch: assert property ($rose(busy) |-> ##1 ref_powered ==
    pd_q[1]) else $error("reference not latched at busy rise");
  a_drive_single: assert property (busy && single_q |-> !panel_drive)
    else $error("panel driven during single-ended conversion");
  a_drive_diff: assert property (busy && !single_q &&
    is_touch(chan_q) |-> panel_drive) else $error("differential drive off");
  a_end_power: assert property (conv_end_w |=> adc_powered ==
    pd_q[0]) else $error("wrong power state at conversion end");
  a_len_bits: assert property (conv_end_w |-> falls_q ==
    (mode8_q ? 4'h6 : 4'hA)) else $error("wrong result length");
  a_msb_first: assert property ($fell(busy) && !cs_s |->
    dout == code_q[11]) else $error("msb not first");
  a_power_hold: assert property ($fell(adc_powered) |->
    $past(cs_rise_w || (conv_end_w && !pd_q[0])))
    else $error("adc dropped without cause");
  a_pen_off: assert property (!pen_en_q && $past(!pen_en_q) &&
    $past(state_q == tpc_pkg::ST_IDLE) |-> pen_touch_irq_n)
    else $error("pen interrupt active while disabled");

  c_full_done: cover property (conv_end_w && !mode8_q);
  c_short_done: cover property (conv_end_w && mode8_q);
  c_abort: cover property (abort_w);
  c_diff_busy: cover property (busy && !single_q && panel_drive);

endmodule // tpc_ctrl
`default_nettype wire

/* File: tpc_host_model.sv */
// holds a behavioural host that drives the serial link of the converter
// assumes the bench calls frame and release_select from one process
`timescale 1ns/1ps
`default_nettype none

module tpc_host_model (
  output logic cs_n,
  output logic serial_clock,
  output logic din,
  input wire logic dout,
  input wire logic busy,
  input wire logic panel_drive
);
  logic s_dout;
  logic s_busy;
  logic s_drv;

  initial begin
    cs_n = 1'b1;
    serial_clock = 1'b0;
    din = 1'b0;
  end

  // ****************************************************************
  // one link clock period, 64 ns
  // ****************************************************************
  // same rate in both modes, inside either limit
  task automatic tick(input logic b);
    din = b;
    #32 serial_clock = 1'b1;
    // sample late in the high phase: dout lags the fall by a few pclk
    #32 s_dout = dout;
    s_busy = busy;
    s_drv = panel_drive;
    serial_clock = 1'b0;
  endtask

  // ****************************************************************
  // one measurement; ncut above zero aborts after that many clocks
  // ****************************************************************
  // pen pin is not watched while a byte goes out
  task automatic frame(input logic [6:0] ctl, input int nbits,
    input int ncut, output logic [11:0] res, output logic drv,
    output logic bsy);
    res = 12'h000;
    drv = 1'b0;
    bsy = 1'b0;
    cs_n = 1'b0;
    // odd offset keeps link edges off the pclk grid
    #101;
    tick(1'b1);
    for (int i = 6; i >= 0; i--) tick(ctl[i]);
    for (int k = 1; k <= nbits + 1; k++) begin
      if (ncut > 0 && k > ncut) break;
      tick(1'b0);
      if (k == 1) begin
        drv = s_drv;
        bsy = s_busy;
      end else res[nbits + 1 - k] = s_dout;
    end
    if (ncut > 0) cs_n = 1'b1;
    #64;
  endtask

  task automatic release_select();
    cs_n = 1'b1;
    #64;
  endtask
endmodule // tpc_host_model
`default_nettype wire

/* File: test_tpc_ctrl.sv */
// holds the self-checking bench of the converter control
// assumes tpc_ctrl, tpc_host_model and tpc_params.svh are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "tpc_params.svh"

module test_tpc_ctrl;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic cs_n, serial_clock, din, panel_touched, dout, dout_oe;
  logic busy, busy_oe, pen_touch_irq_n, panel_drive;
  logic adc_powered, ref_powered;
  logic [11:0] res;
  logic drv, bsy;
  int err_count = 0;
  int total_checks = 0;

  tpc_ctrl u_tpc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .cs_n(cs_n), .serial_clock(serial_clock), .din(din),
    .panel_touched(panel_touched), .dout(dout), .dout_oe(dout_oe),
    .busy(busy), .busy_oe(busy_oe), .pen_touch_irq_n(pen_touch_irq_n),
    .panel_drive(panel_drive), .adc_powered(adc_powered),
    .ref_powered(ref_powered));

  tpc_host_model u_tpc_host_model (.cs_n(cs_n),
    .serial_clock(serial_clock), .din(din), .dout(dout), .busy(busy),
    .panel_drive(panel_drive));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ****************************************************************
  // checking and closing
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] exp,
    input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ****************************************************************
  // apb master
  // ****************************************************************
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk("pready", 32'h1, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a,
    input logic [31:0] exp, input logic exp_er);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0, rd, er);
    chk(nm, exp, rd);
    chk("pslverr", {31'h0, exp_er}, {31'h0, er});
  endtask

  task automatic pins(input logic a, input logic r);
    repeat (2) @(posedge pclk);
    chk("adc_powered", {31'h0, a}, {31'h0, adc_powered});
    chk("ref_powered", {31'h0, r}, {31'h0, ref_powered});
  endtask

  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, panel_touched} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    pins(1'b1, 1'b0);
    chk("pen_irq_n", 32'h1, {31'h0, pen_touch_irq_n});
    rd_chk("status", `TPC_OFS_STATUS, 32'h0000001A, 1'b0);
    rd_chk("unmapped", 8'h14, 32'h0, 1'b1);
    // pd 10: reference on, converter off after the end
    wr(`TPC_OFS_SAMPLE, 32'h00000A5C);
    wr(`TPC_OFS_INT_MASK, 32'h00000007);
    u_tpc_host_model.frame(7'h12, 12, 0, res, drv, bsy);
    chk("result", 32'h00000A5C, {20'h0, res});
    chk("drive", 32'h1, {31'h0, drv});
    chk("busy", 32'h1, {31'h0, bsy});
    pins(1'b0, 1'b1);
    chk("dout_oe", 32'h1, {31'h0, dout_oe});
    chk("busy_oe", 32'h1, {31'h0, busy_oe});
    rd_chk("result_reg", `TPC_OFS_RESULT, 32'h00000A5C, 1'b0);
    chk("irq", 32'h1, {31'h0, irq});
    rd_chk("int_stat", `TPC_OFS_INT_STAT, 32'h3, 1'b0);
    wr(`TPC_OFS_INT_STAT, 32'h00000003);
    rd_chk("int_stat", `TPC_OFS_INT_STAT, 32'h0, 1'b0);
    chk("irq", 32'h0, {31'h0, irq});
    @(posedge pclk);
    panel_touched <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("pen_irq_n", 32'h0, {31'h0, pen_touch_irq_n});
    // pd 01 in short single-ended mode, interrupt masked
    wr(`TPC_OFS_INT_MASK, 32'h00000000);
    u_tpc_host_model.frame(7'h3D, 8, 0, res, drv, bsy);
    chk("result8", 32'h000000A5, {20'h0, res});
    chk("drive", 32'h0, {31'h0, drv});
    pins(1'b1, 1'b0);
    chk("pen_irq_n", 32'h1, {31'h0, pen_touch_irq_n});
    rd_chk("status", `TPC_OFS_STATUS, 32'h00000012, 1'b0);
    rd_chk("result_reg", `TPC_OFS_RESULT, 32'h000000A5, 1'b0);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`TPC_OFS_INT_MASK, 32'h00000007);
    repeat (2) @(posedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`TPC_OFS_INT_STAT, 32'h00000007);
    // pd 11, select raised in mid-result
    u_tpc_host_model.frame(7'h13, 12, 4, res, drv, bsy);
    chk("busy", 32'h1, {31'h0, bsy});
    pins(1'b0, 1'b1);
    chk("dout_oe", 32'h0, {31'h0, dout_oe});
    chk("busy_oe", 32'h0, {31'h0, busy_oe});
    chk("busy_pin", 32'h0, {31'h0, busy});
    rd_chk("int_stat", `TPC_OFS_INT_STAT, 32'h5, 1'b0);
    rd_chk("status", `TPC_OFS_STATUS, 32'h00000014, 1'b0);
    wr(`TPC_OFS_INT_STAT, 32'h00000007);
    // pd 00 byte drops the reference before select goes high
    wr(`TPC_OFS_SAMPLE, 32'h00000FFF);
    u_tpc_host_model.frame(7'h14, 12, 0, res, drv, bsy);
    chk("result", 32'h00000FFF, {20'h0, res});
    chk("drive", 32'h0, {31'h0, drv});
    pins(1'b0, 1'b0);
    u_tpc_host_model.release_select();
    pins(1'b0, 1'b0);
    report_and_stop();
  end
endmodule // test_tpc_ctrl
`default_nettype wire
